// ===== pkg/swcc_consts.vh
// Constants for the standby wake and slow clock control block
`ifndef SWCC_CONSTS_VH
`define SWCC_CONSTS_VH

// Register byte addresses
`define SWCC_ADDR_W          9
`define SWCC_OFF_CLK_CFG     9'h0f0
`define SWCC_OFF_WAKE_EN     9'h0f4
`define SWCC_OFF_WAKE_STS    9'h0f8
`define SWCC_OFF_GPIO_DATA   9'h0fc
`define SWCC_OFF_GPIO_DIR    9'h100
`define SWCC_OFF_KEY_CODE    9'h104
`define SWCC_OFF_STATE       9'h108

// Reset values
`define SWCC_CLK_CFG_RST     8'h00
`define SWCC_WAKE_EN_RST     17'h00000
`define SWCC_GPIO_RST        13'h0000
`define SWCC_KEY_CODE_RST    8'h00

// Field positions
`define SWCC_CFG_ABSENT_BIT  0
`define SWCC_WK_RI1          0
`define SWCC_WK_RI2          1
`define SWCC_WK_KBD          2
`define SWCC_WK_MOUSE        3
`define SWCC_WK_KEY          4
`define SWCC_WK_GPA_LSB      5
`define SWCC_WK_GPB_LSB      13
`define SWCC_WK_W            17
`define SWCC_GPIO_W          13
`define SWCC_GPIO_NOWAKE_BIT 12

// Timing: reference and slow clock rates in Hz
`define SWCC_REF_HZ          14318180
`define SWCC_SLOW_HZ         32768
`define SWCC_REF_DIV         ((`SWCC_REF_HZ + `SWCC_SLOW_HZ / 2) / `SWCC_SLOW_HZ)
`define SWCC_REF_CNT_W       9
// Debounce length and LED half period, in slow clock ticks
`define SWCC_DEB_TICKS       8
`define SWCC_DEB_CNT_W       4
`define SWCC_LED_HALF_TICKS  16384
`define SWCC_LED_CNT_W       15

`endif

// ===== design/swcc_standby_wake_clock_control.v
// Standby wake detection, slow clock selection and register slave
`timescale 1ns/1ps
`default_nettype none
`include "swcc_consts.vh"

// How it works
// (R1) On standby alone, wake detection runs and enabled events pull wake low.
// (R2) Wake sources: both rings, keyboard, mouse, key match, wake GPIOs.
// (R3) GPIO groups A and B feed standby input paths into the wake logic.
// (R4) GPIO without wake path has an output driver only, never wakes.
// (R5) Wake GPIO drivers act only as inputs while main supply is absent.
// (R6) Slow clock config lives in standby domain, reset only by standby reset.
// (R7) Config bit 0 clear means external slow clock present; software sets it.
// (R8) Flag set: key match runs from 32 kHz divided from the reference clock.
// (R9) Board must always supply the external slow clock for debounce and LED.
// (R10) Without external slow clock, key match stops on standby supply alone.
// (R11) Reference clock is treated as absent whenever main supply is off.
// (R12) While main supply good is low, bus reads and writes are not decoded.
// (R13) Wake output and wake inputs stay live while main supply good is low.
// (R14) Standby power-on reset initialises all wake and suspend logic.
// (R15) External slow clock drives debounce, LED blink and, while the flag is clear, key match.
// (R16) Clock-absent flag is resynchronised before key match switches source.
module swcc_standby_wake_clock_control (
  input  wire                    clk_sys_in,
  input  wire                    rstn_in,
  input  wire [`SWCC_ADDR_W-1:0] avs_address_in,
  input  wire                    avs_read_in,
  input  wire                    avs_write_in,
  input  wire [31:0]             avs_writedata_in,
  input  wire [3:0]              avs_byteenable_in,
  output reg  [31:0]             avs_readdata_out,
  output reg                     avs_waitrequest_out,
  input  wire                    main_supply_good_in,
  input  wire                    slow_clock_input_in,
  input  wire                    reference_clock_input_in,
  input  wire                    ring_indicator_one_n_in,
  input  wire                    ring_indicator_two_n_in,
  input  wire                    keyboard_data_line_in,
  input  wire                    mouse_data_line_in,
  input  wire                    front_panel_reset_in_n_in,
  input  wire [7:0]              wake_gpio_group_a_in,
  output reg  [7:0]              wake_gpio_group_a_out,
  output reg  [7:0]              wake_gpio_group_a_oe_out,
  input  wire [3:0]              wake_gpio_group_b_in,
  output reg  [3:0]              wake_gpio_group_b_out,
  output reg  [3:0]              wake_gpio_group_b_oe_out,
  output reg                     gpio_without_wake_path_out,
  output reg                     gpio_without_wake_path_oe_out,
  output reg                     wake_event_out_n,
  output reg                     wake_event_oe_out,
  output reg                     front_panel_reset_db_n_out,
  output reg                     led_blink_out
);

  // Pin synchronisers: stage one feeds stage two only
  localparam SYN_W = 20;
  wire [SYN_W-1:0] pins_raw;
  reg  [SYN_W-1:0] syn1_ff;
  reg  [SYN_W-1:0] syn2_ff;
  reg  [SYN_W-1:0] syn3_ff;
  reg  [2:0]       prime_ff;
  assign pins_raw = {wake_gpio_group_b_in, wake_gpio_group_a_in,
                     front_panel_reset_in_n_in, mouse_data_line_in,
                     keyboard_data_line_in, ring_indicator_two_n_in,
                     ring_indicator_one_n_in, reference_clock_input_in,
                     slow_clock_input_in, main_supply_good_in};

  always @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      syn1_ff <= {SYN_W{1'b1}};
      syn2_ff <= {SYN_W{1'b1}};
      syn3_ff <= {SYN_W{1'b1}};
      prime_ff <= 3'b000;
    end else begin
      syn1_ff <= pins_raw;
      syn2_ff <= syn1_ff;
      syn3_ff <= syn2_ff;
      prime_ff <= {prime_ff[1:0], 1'b1};
    end
  end

  // No edges until stage three holds a real sample: reset makes none
  wire       primed    = prime_ff[2];
  wire       main_good = syn2_ff[0];
  wire       ext_tick  = primed & syn2_ff[1] & ~syn3_ff[1];
  wire       ref_rise  = primed & syn2_ff[2] & ~syn3_ff[2];
  wire       kbd_s     = syn2_ff[5];
  wire       fp_s      = syn2_ff[7];
  wire [3:0] fall4     = syn3_ff[6:3] & ~syn2_ff[6:3] & {4{primed}};
  wire [11:0] gp_chg   = (syn3_ff[19:8] ^ syn2_ff[19:8]) & {12{primed}};

  // Registers
  reg [7:0]               clk_cfg_ff;
  reg [`SWCC_WK_W-1:0]    wake_en_ff;
  reg [`SWCC_WK_W-1:0]    wake_sts_ff;
  reg [`SWCC_GPIO_W-1:0]  gpio_data_ff;
  reg [`SWCC_GPIO_W-1:0]  gpio_dir_ff;
  reg [7:0]               key_code_ff;

  // Internal 32 kHz from the reference clock
  reg  [`SWCC_REF_CNT_W-1:0] ref_cnt_ff;
  wire int_tick = main_good & ref_rise &
                  (ref_cnt_ff == `SWCC_REF_DIV - 1);              // (R8)

  always @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      ref_cnt_ff <= {`SWCC_REF_CNT_W{1'b0}};
    end else if (!main_good) begin
      ref_cnt_ff <= {`SWCC_REF_CNT_W{1'b0}};                      // (R11)
    end else if (ref_rise) begin
      if (int_tick) begin
        ref_cnt_ff <= {`SWCC_REF_CNT_W{1'b0}};
      end else begin
        ref_cnt_ff <= ref_cnt_ff + 1'b1;
      end
    end
  end

  // Key match clock source, switched only on a tick boundary
  reg absent_s1_ff;
  reg absent_s2_ff;
  reg km_int_sel_ff;
  always @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      absent_s1_ff  <= 1'b0;
      absent_s2_ff  <= 1'b0;
      km_int_sel_ff <= 1'b0;
    end else begin
      absent_s1_ff <= clk_cfg_ff[`SWCC_CFG_ABSENT_BIT];              // (R16)
      absent_s2_ff <= absent_s1_ff;
      if (ext_tick | int_tick) begin
        km_int_sel_ff <= absent_s2_ff;                             // (R16)
      end
    end
  end

  // Internal ticks die with main supply, so key match halts then
  wire km_tick = km_int_sel_ff ? int_tick : ext_tick;             // (R10)

  // Key match: sample keyboard data per slow tick, compare to code
  reg [7:0] km_shift_ff;
  reg       km_hit_ff;
  wire      km_hit = (km_shift_ff == key_code_ff) &&
                     (key_code_ff != 8'h00);
  always @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      km_shift_ff <= 8'h00;
      km_hit_ff   <= 1'b0;
    end else begin
      if (km_tick) begin
        km_shift_ff <= {km_shift_ff[6:0], kbd_s};                  // (R15)
      end
      km_hit_ff <= km_hit;
    end
  end
  wire km_event = km_hit & ~km_hit_ff;

  // Front panel reset debounce and LED blink: external clock only
  reg [`SWCC_DEB_CNT_W-1:0] deb_cnt_ff;
  reg [`SWCC_LED_CNT_W-1:0] led_cnt_ff;
  always @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      deb_cnt_ff                 <= {`SWCC_DEB_CNT_W{1'b0}};
      led_cnt_ff                 <= {`SWCC_LED_CNT_W{1'b0}};
      front_panel_reset_db_n_out <= 1'b1;
      led_blink_out              <= 1'b0;
    end else if (ext_tick) begin                                   // (R15)
      if (fp_s == front_panel_reset_db_n_out) begin
        deb_cnt_ff <= {`SWCC_DEB_CNT_W{1'b0}};
      end else if (deb_cnt_ff == `SWCC_DEB_TICKS - 1) begin
        deb_cnt_ff                 <= {`SWCC_DEB_CNT_W{1'b0}};
        front_panel_reset_db_n_out <= fp_s;
      end else begin
        deb_cnt_ff <= deb_cnt_ff + 1'b1;
      end
      if (led_cnt_ff == `SWCC_LED_HALF_TICKS - 1) begin
        led_cnt_ff    <= {`SWCC_LED_CNT_W{1'b0}};
        led_blink_out <= ~led_blink_out;
      end else begin
        led_cnt_ff <= led_cnt_ff + 1'b1;
      end
    end
  end

  // Wake events, gathered whatever the main supply does
  wire [`SWCC_WK_W-1:0] wake_evt = {gp_chg, km_event, fall4};      // (R2) (R3)

  // Bus slave: one wait state, answer at second edge of request
  wire        req     = avs_read_in | avs_write_in;
  wire        take    = req & ~avs_waitrequest_out;
  wire        decode  = main_good;                                 // (R12)
  wire        wr_take = take & avs_write_in & decode;
  wire [31:0] be_mask = {{8{avs_byteenable_in[3]}},
                         {8{avs_byteenable_in[2]}},
                         {8{avs_byteenable_in[1]}},
                         {8{avs_byteenable_in[0]}}};
  wire [31:0] wmask   = wr_take ? be_mask : 32'h00000000;
  wire [31:0] wd      = avs_writedata_in;

  wire hit_cfg  = (avs_address_in == `SWCC_OFF_CLK_CFG);
  wire hit_en   = (avs_address_in == `SWCC_OFF_WAKE_EN);
  wire hit_sts  = (avs_address_in == `SWCC_OFF_WAKE_STS);
  wire hit_gdat = (avs_address_in == `SWCC_OFF_GPIO_DATA);
  wire hit_gdir = (avs_address_in == `SWCC_OFF_GPIO_DIR);
  wire hit_key  = (avs_address_in == `SWCC_OFF_KEY_CODE);

  // Set beats write-one-to-clear in the same cycle
  wire [`SWCC_WK_W-1:0] sts_clr = hit_sts ? wmask[`SWCC_WK_W-1:0]
                                          : {`SWCC_WK_W{1'b0}};
  wire [`SWCC_WK_W-1:0] nxt_wake_sts = (wake_sts_ff & ~(sts_clr & wd[16:0]))
                                       | wake_evt;                 // (R1)

  // Config register: reset only by the standby reset
  always @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      clk_cfg_ff   <= `SWCC_CLK_CFG_RST;                        // (R6) (R14)
      wake_en_ff   <= `SWCC_WAKE_EN_RST;
      wake_sts_ff  <= {`SWCC_WK_W{1'b0}};
      gpio_data_ff <= `SWCC_GPIO_RST;
      gpio_dir_ff  <= `SWCC_GPIO_RST;
      key_code_ff  <= `SWCC_KEY_CODE_RST;
    end else begin
      wake_sts_ff <= nxt_wake_sts;
      if (hit_cfg) begin
        clk_cfg_ff <= (clk_cfg_ff & ~wmask[7:0]) |
                      (wd[7:0] & wmask[7:0]);                      // (R7)
      end
      if (hit_en) begin
        wake_en_ff <= (wake_en_ff & ~wmask[16:0]) | (wd[16:0] & wmask[16:0]);
      end
      if (hit_gdat) begin
        gpio_data_ff <= (gpio_data_ff & ~wmask[12:0]) |
                        (wd[12:0] & wmask[12:0]);
      end
      if (hit_gdir) begin
        gpio_dir_ff <= (gpio_dir_ff & ~wmask[12:0]) |
                       (wd[12:0] & wmask[12:0]);
      end
      if (hit_key) begin
        key_code_ff <= (key_code_ff & ~wmask[7:0]) | (wd[7:0] & wmask[7:0]);
      end
    end
  end

  // Read mux; unmapped or undecoded reads return zero
  reg [31:0] nxt_rdata;
  always @* begin
    nxt_rdata = 32'h00000000;
    if (!decode) begin
      nxt_rdata = 32'h00000000;                                    // (R12)
    end else if (hit_cfg) begin
      nxt_rdata = {24'h000000, clk_cfg_ff};
    end else if (hit_en) begin
      nxt_rdata = {15'h0000, wake_en_ff};
    end else if (hit_sts) begin
      nxt_rdata = {15'h0000, wake_sts_ff};
    end else if (hit_gdat) begin
      nxt_rdata = {19'h00000, gpio_data_ff};
    end else if (hit_gdir) begin
      nxt_rdata = {19'h00000, gpio_dir_ff};
    end else if (hit_key) begin
      nxt_rdata = {24'h000000, key_code_ff};
    end else if (avs_address_in == `SWCC_OFF_STATE) begin
      nxt_rdata = {27'h0000000, led_blink_out,
                   front_panel_reset_db_n_out,
                   km_int_sel_ff & ~main_good, km_int_sel_ff, main_good};
    end
  end

  always @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out    <= 32'h00000000;
    end else begin
      avs_waitrequest_out <= ~(req & avs_waitrequest_out);
      if (req & avs_waitrequest_out) begin
        avs_readdata_out <= avs_read_in ? nxt_rdata : 32'h00000000;
      end
    end
  end

  // Pin drivers and wake output
  wire any_wake = |(nxt_wake_sts & wake_en_ff);
  always @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      wake_gpio_group_a_out         <= 8'h00;
      wake_gpio_group_a_oe_out      <= 8'h00;
      wake_gpio_group_b_out         <= 4'h0;
      wake_gpio_group_b_oe_out      <= 4'h0;
      gpio_without_wake_path_out    <= 1'b0;
      gpio_without_wake_path_oe_out <= 1'b0;
      wake_event_out_n              <= 1'b1;
      wake_event_oe_out             <= 1'b0;
    end else begin
      wake_gpio_group_a_out    <= gpio_data_ff[7:0];
      wake_gpio_group_b_out    <= gpio_data_ff[11:8];
      // Main-supply drivers float when that supply is gone
      wake_gpio_group_a_oe_out <= gpio_dir_ff[7:0] & {8{main_good}};  // (R5)
      wake_gpio_group_b_oe_out <= gpio_dir_ff[11:8] & {4{main_good}}; // (R5)
      gpio_without_wake_path_out    <=
        gpio_data_ff[`SWCC_GPIO_NOWAKE_BIT];                       // (R4)
      gpio_without_wake_path_oe_out <=
        gpio_dir_ff[`SWCC_GPIO_NOWAKE_BIT];                        // (R4)
      // Open drain: drive low only, never gated by main supply
      wake_event_out_n  <= 1'b0;                                   // (R13)
      wake_event_oe_out <= any_wake;                               // (R1)
    end
  end

endmodule // swcc_standby_wake_clock_control

`default_nettype wire

// ===== testbench/swcc_asserts.sv
// Port-level checker for the standby wake and slow clock block
`timescale 1ns/1ps
`default_nettype none
module swcc_asserts (
  input wire logic        clk_sys_in,
  input wire logic        rstn_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out,
  input wire logic        main_supply_good_in,
  input wire logic [7:0]  wake_gpio_group_a_oe_out,
  input wire logic [3:0]  wake_gpio_group_b_oe_out,
  input wire logic        wake_event_out_n,
  input wire logic        wake_event_oe_out,
  input wire logic        front_panel_reset_db_n_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  // Four low samples cover the two-stage supply synchroniser
  property p_answer;
    (avs_read_in || avs_write_in) && avs_waitrequest_out
      |=> !avs_waitrequest_out;
  endproperty
  a_answer: assert property (p_answer) else $error("no bus answer");
  property p_one_low;
    !avs_waitrequest_out |=> avs_waitrequest_out;
  endproperty
  a_one_low: assert property (p_one_low) else $error("wait low twice");
  property p_refuse;
    !main_supply_good_in [*4] ##0 (avs_read_in && avs_waitrequest_out)
      |=> avs_readdata_out == 32'h0;
  endproperty
  a_refuse: assert property (p_refuse) else $error("read decoded");
  property p_rd_hold;
    avs_waitrequest_out && $past(avs_waitrequest_out)
      |-> $stable(avs_readdata_out);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("data moved");
  property p_gpio_off;
    !main_supply_good_in [*4] |-> wake_gpio_group_a_oe_out == 8'h00
      && wake_gpio_group_b_oe_out == 4'h0;
  endproperty
  a_gpio_off: assert property (p_gpio_off) else $error("gpio driven");
  property p_od;
    wake_event_oe_out |-> !wake_event_out_n;
  endproperty
  a_od: assert property (p_od) else $error("wake drives high");
  property p_hold_down;
    !main_supply_good_in [*4] ##0 wake_event_oe_out |=> wake_event_oe_out;
  endproperty
  a_hold_down: assert property (p_hold_down) else $error("wake lost");
  property p_fp_deb;
    $changed(front_panel_reset_db_n_out)
      |=> $stable(front_panel_reset_db_n_out) [*8];
  endproperty
  a_fp_deb: assert property (p_fp_deb) else $error("bounce seen");
endmodule // swcc_asserts
bind swcc_standby_wake_clock_control swcc_asserts i_chk (
  .clk_sys_in, .rstn_in, .avs_read_in, .avs_write_in, .avs_readdata_out,
  .avs_waitrequest_out, .main_supply_good_in, .wake_gpio_group_a_oe_out,
  .wake_gpio_group_b_oe_out, .wake_event_out_n, .wake_event_oe_out,
  .front_panel_reset_db_n_out);
`default_nettype wire

// ===== testbench/swcc_board_model.sv
// Board side: trickle clock source and pulled-up wake line to chipset
`timescale 1ns/1ps
`default_nettype none
module swcc_board_model #(
  parameter real HALF_NS = 200.0
) (
  input  wire logic grounded_in,
  input  wire logic wake_n_in,
  input  wire logic wake_oe_in,
  output var  logic slow_clk_out,
  output wire logic wake_line_out
);
  // Sped up so debounce and key match fit the run
  initial slow_clk_out = 1'b0;
  always #(HALF_NS) slow_clk_out = grounded_in ? 1'b0 : ~slow_clk_out;
  // Pull-up holds the line high when nobody pulls
  assign wake_line_out = wake_oe_in ? wake_n_in : 1'b1;
endmodule // swcc_board_model
`default_nettype wire

// ===== testbench/tb_top.sv
// Self-checking bench for the standby wake and slow clock block
`timescale 1ns/1ps
`default_nettype none
`include "swcc_consts.vh"
module tb_top;
  logic        clk = 0, rstn = 0, mg = 1, rclk = 0, fp = 1, gnd = 0;
  logic        rd = 0, wr = 0;
  logic [8:0]  addr = 9'h000;
  logic [31:0] wd = 32'h0, d;
  logic [16:0] pins = 17'h0000f;
  logic [63:0] note;
  logic [63:0] q[$];
  wire  [31:0] rdat;
  wire  [7:0]  a_o, a_oe;
  wire  [3:0]  b_o, b_oe;
  wire         wt, nw_o, nw_oe, wk_n, wk_oe, fp_db, led, slow, wline;
  int          error_cnt = 0, tests_run = 0, cyc = 0, i;

  always #5 clk = ~clk;
  always #34.92 rclk = mg ? ~rclk : 1'b0;

  swcc_standby_wake_clock_control i_dut (
    .clk_sys_in(clk), .rstn_in(rstn), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
    .avs_byteenable_in(4'hf), .avs_readdata_out(rdat),
    .avs_waitrequest_out(wt), .main_supply_good_in(mg),
    .slow_clock_input_in(slow), .reference_clock_input_in(rclk),
    .ring_indicator_one_n_in(pins[0]), .ring_indicator_two_n_in(pins[1]),
    .keyboard_data_line_in(pins[2]), .mouse_data_line_in(pins[3]),
    .front_panel_reset_in_n_in(fp), .wake_gpio_group_a_in(pins[12:5]),
    .wake_gpio_group_a_out(a_o), .wake_gpio_group_a_oe_out(a_oe),
    .wake_gpio_group_b_in(pins[16:13]), .wake_gpio_group_b_out(b_o),
    .wake_gpio_group_b_oe_out(b_oe), .gpio_without_wake_path_out(nw_o),
    .gpio_without_wake_path_oe_out(nw_oe), .wake_event_out_n(wk_n),
    .wake_event_oe_out(wk_oe), .front_panel_reset_db_n_out(fp_db),
    .led_blink_out(led));
  swcc_board_model i_board (.grounded_in(gnd), .wake_n_in(wk_n),
    .wake_oe_in(wk_oe), .slow_clk_out(slow), .wake_line_out(wline));

  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task give_verdict;
    $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Request held until the edge that sees waitrequest low
  task bus(input logic w, input logic [8:0] a, input logic [31:0] dd);
    @(posedge clk);
    rd <= ~w; wr <= w; addr <= a; wd <= dd;
    do @(posedge clk); while (wt !== 1'b0);
    rd <= 1'b0; wr <= 1'b0;
  endtask
  task rdx(input logic [8:0] a, input logic [31:0] e, input logic [31:0] m);
    q.push_back({m, e});
    bus(1'b0, a, 32'h0);
  endtask
  task wait_oe(input int n);
    int c;
    for (c = 0; c < n && wk_oe !== 1'b1; c++) @(posedge clk);
    check(wk_oe, 1);
  endtask
  // Oldest note answers the read completing at this edge
  always @(posedge clk) if (rd && wt === 1'b0 && q.size() > 0) begin
    note = q.pop_front();
    check(rdat & note[63:32], note[31:0]);
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      give_verdict();
    end
  end

  initial begin
    void'($urandom(32'h093079a2));
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    rdx(`SWCC_OFF_CLK_CFG, 32'h0, 32'hff);
    rdx(`SWCC_OFF_WAKE_EN, 32'h0, 32'h1ffff);
    rdx(`SWCC_OFF_STATE, 32'h1, 32'h1);
    d = $urandom;
    bus(1'b1, `SWCC_OFF_CLK_CFG, d);
    bus(1'b1, 9'h1fc, d);
    rdx(`SWCC_OFF_CLK_CFG, d & 32'hff, 32'hffffffff);
    rdx(9'h1fc, 32'h0, 32'hffffffff);
    mg <= 1'b0;
    repeat (4) @(posedge clk);
    bus(1'b1, `SWCC_OFF_CLK_CFG, ~d);
    rdx(`SWCC_OFF_CLK_CFG, 32'h0, 32'hffffffff);
    mg <= 1'b1;
    repeat (4) @(posedge clk);
    rdx(`SWCC_OFF_CLK_CFG, d & 32'hff, 32'hff);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    rdx(`SWCC_OFF_CLK_CFG, 32'h0, 32'hff);
    $display("test registers done");
    fp <= 1'b0;
    repeat (600) @(posedge clk);
    check(fp_db, 0);
    fp <= 1'b1;
    repeat (600) @(posedge clk);
    check(fp_db, 1);
    check(led, 1'b0);
    d = $urandom & 32'h1fff;
    bus(1'b1, `SWCC_OFF_GPIO_DATA, d);
    bus(1'b1, `SWCC_OFF_GPIO_DIR, 32'h1fff);
    repeat (2) @(posedge clk);
    check({nw_o, b_o, a_o}, d);
    check({nw_oe, b_oe, a_oe}, 32'h1fff);
    mg <= 1'b0;
    repeat (4) @(posedge clk);
    check({nw_oe, b_oe, a_oe}, 32'h1000);
    mg <= 1'b1;
    repeat (4) @(posedge clk);
    bus(1'b1, `SWCC_OFF_GPIO_DIR, 32'h0);
    $display("test debounce and gpio done");
    // Even sources enabled, odd ones only latch status
    for (i = 0; i < 17; i++) if (i != 4) begin
      d = (i % 2 == 0) ? (32'h1 << i) : 32'h0;
      bus(1'b1, `SWCC_OFF_WAKE_EN, d);
      mg <= 1'b0;
      repeat (4) @(posedge clk);
      pins[i] <= ~pins[i];
      repeat (8) @(posedge clk);
      check(wk_oe, d != 0);
      check(wline, d == 0);
      mg <= 1'b1;
      repeat (4) @(posedge clk);
      rdx(`SWCC_OFF_WAKE_STS, 32'h1 << i, 32'h1ffff);
      pins[i] <= ~pins[i];
      repeat (8) @(posedge clk);
      bus(1'b1, `SWCC_OFF_WAKE_STS, 32'h1ffff);
      @(posedge clk);
      check(wk_oe, 0);
    end
    $display("test wake sources done");
    bus(1'b1, `SWCC_OFF_KEY_CODE, 32'hff);
    bus(1'b1, `SWCC_OFF_WAKE_EN, 32'h10);
    wait_oe(800);
    pins[2] <= 1'b0;
    repeat (800) @(posedge clk);
    bus(1'b1, `SWCC_OFF_WAKE_STS, 32'h1ffff);
    @(posedge clk);
    check(wk_oe, 0);
    bus(1'b1, `SWCC_OFF_CLK_CFG, 32'h1);
    gnd <= 1'b1;
    pins[2] <= 1'b1;
    wait_oe(32000);
    rdx(`SWCC_OFF_STATE, 32'h2, 32'h2);
    $display("test key match done");
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
